/* cpuad_core.sv */
`timescale 1ns/1ps
// Functional notes
// - 8-bit program counter low byte, zero at reset, read only
// - immediate source writes A, F, SP or X as opcode selects
// - immediate arithmetic pairs operand with selected A, X, SP or F
// - single-operand modes are two bytes long
// - direct destination with immediate source is three bytes long
// - direct source reads memory at operand, result into A or X
// - source memory modes use selected A or X as second operand
// - indexed source address is operand plus X
// - direct destination stores A or X at operand address
// - destination arithmetic reads destination; accumulator stays unchanged
// - indexed destination address is operand plus X, source is A
// - indexed destination arithmetic reads and writes operand plus X
// - second operand is immediate, first operand is result address
// - each access goes to register space or RAM per opcode
// - immediate AND into flags stores masked flags back
// - flags bit 4 selects register bank 0 or 1
module cpuad_core
  import cpuad_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ==========================================
  // state
  typedef struct packed {
    // core registers
    logic [7:0] a;
    logic [7:0] x;
    logic [7:0] sp;
    logic [7:0] f;
    logic [7:0] pcl;
    // fetched operand bytes and last command
    logic [7:0] op1;
    logic [7:0] op2;
    cpuad_cmd_t cmd;
    // debug window into storage
    logic [7:0] peek_addr;
    logic peek_space;
    // outcome of the last command
    logic [7:0] last_ea;
    logic [1:0] last_len;
    logic err;
    // registered bus answer
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // data storage: RAM and two register banks
    logic [255:0][7:0] ram;
    logic [1:0][255:0][7:0] regsp;
  } cpuad_state_t;

  cpuad_state_t s_q;
  cpuad_state_t s_d;

  // ==========================================
  // decode and execute
  cpuad_cmd_t cmd;
  logic bank;
  logic idx;
  logic [7:0] ea;
  logic [7:0] mem_rd;
  logic [7:0] sel_val;
  logic [7:0] ax_val;
  logic [7:0] src;
  logic [7:0] second;
  logic [8:0] sum;
  logic [7:0] res;
  logic to_mem;
  cpuad_sel_t tsel;
  logic [1:0] len;
  logic valid;
  logic setup;
  logic access;
  logic [7:0] peek_rd;
  // operation side effects
  logic arith;
  logic flag_upd;
  logic res_zero;
  logic [7:0] pcl_next;

  always_comb begin
    s_d = s_q;
    // command word is decoded straight from the write data of a command write
    cmd = cpuad_cmd_t'(pwdata[CMD_W-1:0]);
    // a transfer is acted on only in the access cycle that carries pready
    setup = psel & ~penable;
    access = psel & penable & s_q.pready;

    // ==========================================
    // effective address and storage read
    bank = s_q.f[F_BANK];
    case (cmd.mode)
      MODE_SRC_IDX, MODE_DST_IDX: idx = 1'b1;
      default: idx = 1'b0;
    endcase
    // 8-bit sum drops the carry, so the index wraps inside the space
    ea = s_q.op1 + (idx ? s_q.x : RST_BYTE);
    if (cmd.space) begin
      mem_rd = s_q.regsp[bank][ea];
    end else begin
      mem_rd = s_q.ram[ea];
    end

    // ==========================================
    // register operands
    case (cmd.sel)
      SEL_A: sel_val = s_q.a;
      SEL_X: sel_val = s_q.x;
      SEL_SP: sel_val = s_q.sp;
      SEL_F: sel_val = s_q.f;
      default: sel_val = s_q.a;
    endcase
    // memory modes only name A or X; the other codes fall back to A
    if (cmd.sel == SEL_X) begin
      ax_val = s_q.x;
    end else begin
      ax_val = s_q.a;
    end

    // ==========================================
    // operand routing per addressing mode
    src = s_q.op1;
    second = sel_val;
    to_mem = 1'b0;
    tsel = cmd.sel;
    len = LEN_SHORT;
    valid = 1'b1;
    case (cmd.mode)
      MODE_SRC_IMM: begin
        src = s_q.op1;
        second = sel_val;
      end
      MODE_SRC_DIR, MODE_SRC_IDX: begin
        src = mem_rd;
        second = ax_val;
        if (cmd.sel == SEL_X) begin
          tsel = SEL_X;
        end else begin
          tsel = SEL_A;
        end
      end
      MODE_DST_DIR: begin
        // A or X is read here; neither is written in destination modes
        src = ax_val;
        second = mem_rd;
        to_mem = 1'b1;
      end
      MODE_DST_IDX: begin
        src = s_q.a;
        second = mem_rd;
        to_mem = 1'b1;
      end
      MODE_DST_DIR_IMM: begin
        // three bytes: opcode, result address, immediate
        src = s_q.op2;
        second = mem_rd;
        to_mem = 1'b1;
        len = LEN_LONG;
      end
      default: begin
        // codes 6 and 7 are not addressing modes here
        valid = 1'b0;
      end
    endcase

    // ==========================================
    // arithmetic and logic unit
    sum = {1'b0, second} + {1'b0, src};
    case (cmd.alu)
      ALU_MOV: res = src;
      ALU_ADD: res = sum[7:0];
      ALU_AND: res = second & src;
      ALU_OR: res = second | src;
      ALU_XOR: res = second ^ src;
      default: res = src;
    endcase
    res_zero = (res == RST_BYTE);
    // flags follow every operation but a move, and never a direct write of F
    arith = (cmd.alu != ALU_MOV);
    flag_upd = arith && !(tsel == SEL_F && !to_mem);
    // program counter low byte steps over opcode and operand bytes, wrapping
    pcl_next = s_q.pcl + {6'h00, len};

    // ==========================================
    // debug peek window, using the bank of the running code
    if (s_q.peek_space) begin
      peek_rd = s_q.regsp[bank][s_q.peek_addr];
    end else begin
      peek_rd = s_q.ram[s_q.peek_addr];
    end

    // ==========================================
    // bus answer, registered for the first access cycle
    s_d.pready = setup;
    s_d.pslverr = 1'b0;
    s_d.prdata = RST_WORD;
    if (setup) begin
      case (paddr)
        OFS_CMD: s_d.prdata = {23'h00_0000, s_q.cmd};
        OFS_OPND: s_d.prdata = {16'h0000, s_q.op2, s_q.op1};
        OFS_CORE: s_d.prdata = {s_q.f, s_q.sp, s_q.x, s_q.a};
        OFS_PCL: s_d.prdata = {24'h00_0000, s_q.pcl};
        OFS_PEEK: s_d.prdata = {23'h00_0000, s_q.peek_space, s_q.peek_addr};
        OFS_PEEK_DATA: s_d.prdata = {24'h00_0000, peek_rd};
        OFS_STATUS: s_d.prdata = {21'h00_0000, s_q.err, s_q.last_len, s_q.last_ea};
        // unmapped or unaligned word: error, data stays zero
        default: s_d.pslverr = 1'b1;
      endcase
      // only a read carries data back
      if (pwrite) begin
        s_d.prdata = RST_WORD;
      end
    end

    // ==========================================
    // register writes and command execution
    if (access && pwrite) begin
      case (paddr)
        OFS_OPND: begin
          // operands are loaded before the command that uses them
          s_d.op1 = pwdata[7:0];
          s_d.op2 = pwdata[OPND2_LSB +: 8];
        end
        OFS_PEEK: begin
          s_d.peek_addr = pwdata[7:0];
          s_d.peek_space = pwdata[PEEK_SPACE_BIT];
        end
        OFS_CMD: begin
          s_d.cmd = cmd;
          s_d.err = ~valid;
          if (valid) begin
            s_d.pcl = pcl_next;
            s_d.last_len = len;
            if (to_mem) begin
              s_d.last_ea = ea;
            end else begin
              s_d.last_ea = s_q.op1;
            end
            if (to_mem) begin
              // register space goes to the bank picked by the bank select flag
              if (cmd.space) begin
                s_d.regsp[bank][ea] = res;
              end else begin
                s_d.ram[ea] = res;
              end
            end else begin
              case (tsel)
                SEL_A: s_d.a = res;
                SEL_X: s_d.x = res;
                SEL_SP: s_d.sp = res;
                // reserved and supervisory flag bits keep their value
                SEL_F: s_d.f = (res & FLAGS_WMASK) | (s_q.f & ~FLAGS_WMASK);
                default: s_d.a = res;
              endcase
            end
            if (flag_upd) begin
              s_d.f[F_ZERO] = res_zero;
              // carry exists only for addition; logic operations leave it
              if (cmd.alu == ALU_ADD) begin
                s_d.f[F_CARRY] = sum[8];
              end
            end
          end
        end
        OFS_CORE, OFS_PCL, OFS_PEEK_DATA, OFS_STATUS: begin
          // read-only words ignore writes without error
          s_d.err = s_q.err;
        end
        default: begin
          s_d.err = s_q.err;
        end
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      // flags leave reset with only the zero flag set
      s_q.f <= RST_FLAGS;
      s_q.pcl <= RST_BYTE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs, straight from the state register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;

endmodule

/* cpuad_core_asserts.sv */
`timescale 1ns/1ps
module cpuad_core_asserts
  import cpuad_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========================================
  // shadow of program counter and length
  logic [7:0] pc_q;
  logic [1:0] len_q;
  wire logic cmd_ok = pready && pwrite && paddr == OFS_CMD && pwdata[2:0] <= 3'h5;
  wire logic [1:0] len_w = (pwdata[2:0] == 3'h5) ? LEN_LONG : LEN_SHORT;
  wire logic rd_ok = pready && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= 8'h00;
      len_q <= 2'h0;
    end else if (cmd_ok) begin
      pc_q <= pc_q + {6'h00, len_w};
      len_q <= len_w;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_ready_next; psel && !penable |=> pready && psel && penable; endproperty
  a_ready_next: assert property (p_ready_next) else $error("pready missing");
  property p_ready_once; pready |=> !pready; endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready too long");
  property p_ready_acc; pready |-> psel && penable; endproperty
  a_ready_acc: assert property (p_ready_acc) else $error("pready outside access");
  property p_err_bad;
    psel && !penable && (paddr > OFS_STATUS || paddr[1:0] != 2'h0) |=> pslverr;
  endproperty
  a_err_bad: assert property (p_err_bad) else $error("pslverr missing");
  property p_err_ok;
    psel && !penable && paddr <= OFS_STATUS && paddr[1:0] == 2'h0 |=> !pslverr;
  endproperty
  a_err_ok: assert property (p_err_ok) else $error("pslverr unexpected");
  property p_rdata_idle; !rd_ok |-> prdata == RST_WORD; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("prdata not zero");
  property p_pcl; rd_ok && paddr == OFS_PCL |-> prdata == {24'h00_0000, pc_q}; endproperty
  a_pcl: assert property (p_pcl) else $error("pcl wrong");
  property p_len; rd_ok && paddr == OFS_STATUS && !prdata[10] |-> prdata[9:8] == len_q;
  endproperty
  a_len: assert property (p_len) else $error("length wrong");
  property p_flags; rd_ok && paddr == OFS_CORE |-> prdata[31:29] == 3'h0 && !prdata[27];
  endproperty
  a_flags: assert property (p_flags) else $error("flags reserved bits");
  c_cmd: cover property (cmd_ok);
  c_status: cover property (rd_ok && paddr == OFS_STATUS);
  c_err: cover property (pslverr);
endmodule

bind cpuad_core cpuad_core_asserts u_cpuad_core_asserts (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* cpuad_pkg.sv */
// ==========================================
// register map and reset values
package cpuad_pkg;
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_OPND = 8'h04;
  localparam logic [7:0] OFS_CORE = 8'h08;
  localparam logic [7:0] OFS_PCL = 8'h0C;
  localparam logic [7:0] OFS_PEEK = 8'h10;
  localparam logic [7:0] OFS_PEEK_DATA = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h02;
  localparam logic [7:0] FLAGS_WMASK = 8'h17;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  localparam int F_ZERO = 1;
  localparam int F_CARRY = 2;
  localparam int F_BANK = 4;

  localparam int CMD_W = 9;
  localparam int OPND2_LSB = 8;
  localparam int PEEK_SPACE_BIT = 8;
  localparam int ST_LEN_LSB = 8;
  localparam int ST_ERR_BIT = 10;

  localparam logic [1:0] LEN_SHORT = 2'h2;
  localparam logic [1:0] LEN_LONG = 2'h3;

  // ==========================================
  // command encodings
  typedef enum logic [2:0] {
    MODE_SRC_IMM = 3'b000,
    MODE_SRC_DIR = 3'b001,
    MODE_SRC_IDX = 3'b010,
    MODE_DST_DIR = 3'b011,
    MODE_DST_IDX = 3'b100,
    MODE_DST_DIR_IMM = 3'b101
  } cpuad_mode_t;

  typedef enum logic [2:0] {
    ALU_MOV = 3'b000,
    ALU_ADD = 3'b001,
    ALU_AND = 3'b010,
    ALU_OR = 3'b011,
    ALU_XOR = 3'b100
  } cpuad_alu_t;

  typedef enum logic [1:0] {
    SEL_A = 2'b00,
    SEL_X = 2'b01,
    SEL_SP = 2'b10,
    SEL_F = 2'b11
  } cpuad_sel_t;

  typedef struct packed {
    logic space;
    cpuad_sel_t sel;
    cpuad_alu_t alu;
    cpuad_mode_t mode;
  } cpuad_cmd_t;
endpackage

/* tb_cpuad_core.sv */
`timescale 1ns/1ps
module tb_cpuad_core
  import cpuad_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er;
  logic [79:0] rows [18];
  logic [7:0] pc;
  int fail_count = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  cpuad_core u_cpuad_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  // ==========================================
  // tasks
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic summarize();
    $display("checked %0d, failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // rows: cmd, operands, peek, read addr, shift, mask, expected
  initial begin
    rows = '{80'h0000_0050_0008_000F_F005, 80'h0400_0030_0008_080F_F003,
      80'h0080_0070_0008_000F_F00C, 80'h0040_0100_0018_003F_F213,
      80'h00D0_5130_1314_000F_F011, 80'h00A0_0100_0008_000F_F01D,
      80'h00B0_0130_0008_000F_F01D, 80'h0010_0130_0008_000F_F02E,
      80'h1055_5130_1314_000F_F02E, 80'h1010_0130_0008_000F_F055,
      80'h0D80_0100_0008_180F_F010, 80'h1010_0131_1314_000F_F000,
      80'h0D00_0050_0008_180F_F000, 80'h0000_0090_0008_000F_F009,
      80'h0400_0F00_0008_080F_F0F0, 80'h0040_0200_0018_003F_F210,
      80'h00C0_0200_1014_000F_F012, 80'h0800_0090_0008_100F_F009};
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    pc = 8'h00;
    foreach (rows[i]) begin
      apb(1'h1, OFS_OPND, {16'h0000, rows[i][67:52]});
      apb(1'h1, OFS_CMD, {20'h0_0000, rows[i][79:68]});
      pc = pc + ((rows[i][70:68] == 3'h5) ? 8'h03 : 8'h02);
      apb(1'h0, OFS_STATUS, 32'h0000_0000);
      check("len", (rows[i][70:68] == 3'h5) ? 32'h0000_0300 : 32'h0000_0200,
        rd & 32'h0000_0300);
      apb(1'h1, OFS_PEEK, {20'h0_0000, rows[i][51:40]});
      apb(1'h0, rows[i][39:32], 32'h0000_0000);
      check("row", {20'h0_0000, rows[i][11:0]},
        (rd >> rows[i][31:24]) & {20'h0_0000, rows[i][23:12]});
      $display("row %0d done", i);
    end
    apb(1'h1, OFS_PCL, 32'h0000_00FF);
    apb(1'h0, OFS_PCL, 32'h0000_0000);
    check("pcl", {24'h00_0000, pc}, rd);
    apb(1'h1, OFS_CMD, 32'h0000_0006);
    apb(1'h0, OFS_STATUS, 32'h0000_0000);
    check("bad_mode", 32'h0000_0400, rd & 32'h0000_0400);
    apb(1'h0, OFS_PCL, 32'h0000_0000);
    check("pcl_hold", {24'h00_0000, pc}, rd);
    apb(1'h0, 8'h40, 32'h0000_0000);
    check("unmapped", 32'h0000_0001, rd | {31'h0000_0000, er});
    $display("awkward cases done");
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFS_CORE, 32'h0000_0000);
    check("reset_core", 32'h0200_0000, rd);
    apb(1'h0, OFS_PCL, 32'h0000_0000);
    check("reset_pcl", 32'h0000_0000, rd);
    $display("reset test done");
    summarize();
  end
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
endmodule
